// *** hw/ata_tf_consts.svh ***
`ifndef ATA_TF_CONSTS_SVH
`define ATA_TF_CONSTS_SVH

// ==========================================================================
// Register select codes on the shadow register port
`define TF_SEL_DATA      4'h0
`define TF_SEL_ERR_FEAT  4'h1
`define TF_SEL_COUNT     4'h2
`define TF_SEL_ADDR0     4'h3
`define TF_SEL_ADDR1     4'h4
`define TF_SEL_ADDR2     4'h5
`define TF_SEL_DEVHEAD   4'h6
`define TF_SEL_STAT_CMD  4'h7
`define TF_SEL_CTRL_AUX  4'hE
`define TF_SEL_MIRROR    4'hF

// ==========================================================================
// Field positions
`define DH_LBA_BIT       6
`define DH_DRV_BIT       4
`define CTRL_HOB_BIT     7
`define CTRL_SRST_BIT    2
`define CTRL_NIEN_BIT    1

// ==========================================================================
// Reset values and fixed figures
`define TF_BYTE_RST      8'h00
`define TF_WORD_RST      16'h0000
`define TF_COUNT_RST     9'h000
`define TF_STATUS_BUSY   8'h80
`define TF_SECTORS_MAX   9'h100
`define TF_BUF_FULL      2'h2

`endif

// *** hw/ata_tf_pkg.sv ***
package ata_tf_pkg;

	// ======================================================================
	// Phases of the task file
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_SRST = 2'b11
	} tf_phase_t;

	// ======================================================================
	// Error causes reported by the drive engine
	typedef struct packed {
		logic bad_block_flag;
		logic uncorrectable_flag;
		logic sector_id_missing_flag;
		logic command_aborted_flag;
		logic general_error_flag;
	} err_flags_t;

	typedef struct packed {
		logic       done;
		logic       sector_done;
		logic       corrected;
		err_flags_t err;
	} eng_event_t;

	typedef struct packed {
		logic ready;
		logic write_fault;
		logic transfer_request;
		logic writing;
	} eng_level_t;

	// ======================================================================
	// Host access on the shadow register port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  sel;
		logic [15:0] wdata;
	} tf_req_t;

	// ======================================================================
	// Decoded transfer parameters for the drive engine
	typedef struct packed {
		logic        lba_mode;
		logic [27:0] lba;
		logic [15:0] cylinder;
		logic [3:0]  head;
		logic [7:0]  sector;
		logic [8:0]  sectors;
	} xfer_addr_t;

	// ======================================================================
	// Whole state of the register bank
	typedef struct packed {
		tf_phase_t       phase;
		logic [7:0]      error_cause;
		logic [7:0]      feature_select;
		logic [8:0]      remain;
		logic [7:0]      address_byte0;
		logic [7:0]      address_byte1;
		logic [7:0]      address_byte2;
		logic [7:0]      devhead;
		logic [7:0]      prev_count;
		logic [7:0]      prev_byte0;
		logic [7:0]      prev_byte1;
		logic [7:0]      prev_byte2;
		logic [7:0]      prev_devhead;
		logic            high_order_readback;
		logic            soft_reset_bit;
		logic            interrupt_disable_bit;
		logic            corrected_data_flag;
		logic            error_flag;
		logic            irq_pending;
		logic            drq_seen;
		logic            cmd_valid;
		logic [7:0]      cmd_code;
		logic [15:0]     rdata;
		logic            rvalid;
		logic [1:0][15:0] wbuf;
		logic [1:0]      wcnt;
		logic            whead;
		logic [1:0][15:0] rbuf;
		logic [1:0]      rcnt;
		logic            rhead;
	} tf_state_t;

endpackage : ata_tf_pkg

// *** hw/ata_task_file_registers.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ata_tf_consts.svh"

module ata_task_file_registers (
	input  wire logic                   ref_clk_i,
	input  wire logic                   arst_n_i,
	input  wire ata_tf_pkg::tf_req_t    tf_req_i,
	output logic                        tf_ready_o,
	output logic [15:0]                 tf_rdata_o,
	output logic                        tf_rvalid_o,
	input  wire ata_tf_pkg::eng_level_t eng_level_i,
	input  wire ata_tf_pkg::eng_event_t eng_event_i,
	output logic                        cmd_valid_o,
	output logic [7:0]                  cmd_code_o,
	output logic [7:0]                  feature_o,
	output ata_tf_pkg::xfer_addr_t      xfer_o,
	output logic                        busy_o,
	output logic                        soft_reset_o,
	output logic                        intrq_o,
	output logic [15:0]                 dev_wdata_o,
	output logic                        dev_wvalid_o,
	input  wire logic                   dev_wready_i,
	input  wire logic [15:0]            dev_rdata_i,
	input  wire logic                   dev_rvalid_i,
	output logic                        dev_rready_o
);

	// ======================================================================
	// State
	ata_tf_pkg::tf_state_t s_q;
	ata_tf_pkg::tf_state_t s_d;

	logic       busy;
	logic       taken;
	logic       is_data;
	logic       w_push;
	logic       w_pop;
	logic       r_push;
	logic       r_pop;
	logic [7:0] status;
	logic [7:0] mirror;
	logic [7:0] count_now;
	logic       w_slot;
	logic       r_slot;
	logic       status_rd;
	logic       cmd_block_wr;
	logic       ctrl_wr;
	logic [7:0] shown_count;
	logic [7:0] shown_byte0;
	logic [7:0] shown_byte1;
	logic [7:0] shown_byte2;
	logic [7:0] shown_devhead;

	// ======================================================================
	// Status and mirror composition
	always_comb begin
		// Busy drops while data is requested so the host can move it
		busy = (s_q.phase == ata_tf_pkg::ST_SRST) ||
			((s_q.phase == ata_tf_pkg::ST_EXEC) &&
			!eng_level_i.transfer_request);
		count_now = s_q.remain[7:0];
		// While busy no other status bit may be trusted
		if (busy) begin
			status = `TF_STATUS_BUSY;
		end else begin
			status = {1'b0,
				eng_level_i.ready,
				eng_level_i.write_fault,
				eng_level_i.ready,
				eng_level_i.transfer_request,
				s_q.corrected_data_flag,
				1'b0,
				s_q.error_flag};
		end
		// Only drive 0 exists, so drive 1 always reads unselected
		mirror = {1'b0,
			~eng_level_i.writing,
			~s_q.devhead[3:0],
			1'b1,
			s_q.devhead[`DH_DRV_BIT]};
	end

	// ======================================================================
	// Readback selection: previous values under high-order readback
	always_comb begin
		if (s_q.high_order_readback) begin
			shown_count   = s_q.prev_count;
			shown_byte0   = s_q.prev_byte0;
			shown_byte1   = s_q.prev_byte1;
			shown_byte2   = s_q.prev_byte2;
			shown_devhead = s_q.prev_devhead;
		end else begin
			shown_count   = count_now;
			shown_byte0   = s_q.address_byte0;
			shown_byte1   = s_q.address_byte1;
			shown_byte2   = s_q.address_byte2;
			shown_devhead = s_q.devhead;
		end
	end

	// ======================================================================
	// Host port handshake and buffer strobes
	always_comb begin
		is_data    = (tf_req_i.sel == `TF_SEL_DATA);
		tf_ready_o = !(is_data &&
			((tf_req_i.wr && (s_q.wcnt == `TF_BUF_FULL)) ||
			(tf_req_i.rd && (s_q.rcnt == 2'h0))));
		taken  = (tf_req_i.wr || tf_req_i.rd) && tf_ready_o;
		w_push = taken && tf_req_i.wr && is_data && !busy;
		r_pop  = taken && tf_req_i.rd && is_data;
		w_pop  = (s_q.wcnt != 2'h0) && dev_wready_i;
		r_push = dev_rvalid_i && (s_q.rcnt != `TF_BUF_FULL);
		// Write slot is the free entry behind the head when one is held
		w_slot = s_q.whead ^ (s_q.wcnt != 2'h0);
		r_slot = s_q.rhead ^ (s_q.rcnt != 2'h0);
		status_rd    = taken && tf_req_i.rd &&
			(tf_req_i.sel == `TF_SEL_STAT_CMD);
		// Command block writes while busy are taken and dropped
		cmd_block_wr = taken && tf_req_i.wr && !busy &&
			(tf_req_i.sel <= `TF_SEL_STAT_CMD);
		ctrl_wr      = taken && tf_req_i.wr &&
			(tf_req_i.sel == `TF_SEL_CTRL_AUX);
	end

	// ======================================================================
	// Next state
	always_comb begin
		s_d           = s_q;
		s_d.cmd_valid = 1'b0;
		s_d.rvalid    = 1'b0;

		// Drive-bound data buffer
		// Push and pop may share a cycle; the count nets out
		if (w_push) begin
			s_d.wbuf[w_slot] = tf_req_i.wdata;
		end
		if (w_pop) begin
			s_d.whead = ~s_q.whead;
		end
		s_d.wcnt = s_q.wcnt + {1'b0, w_push} - {1'b0, w_pop};

		// Host-bound data buffer
		if (r_push) begin
			s_d.rbuf[r_slot] = dev_rdata_i;
		end
		if (r_pop) begin
			s_d.rhead = ~s_q.rhead;
		end
		s_d.rcnt = s_q.rcnt + {1'b0, r_push} - {1'b0, r_pop};

		// Engine events
		if (s_q.phase == ata_tf_pkg::ST_EXEC) begin
			// A sector finishing with nothing left is ignored
			if (eng_event_i.sector_done && (s_q.remain != `TF_COUNT_RST))
			begin
				s_d.remain = s_q.remain - 9'h001;
			end
			if (eng_event_i.corrected) begin
				s_d.corrected_data_flag = 1'b1;
			end
			if (eng_event_i.done) begin
				s_d.phase       = ata_tf_pkg::ST_IDLE;
				s_d.error_cause = {eng_event_i.err.bad_block_flag,
					eng_event_i.err.uncorrectable_flag, 1'b0,
					eng_event_i.err.sector_id_missing_flag, 1'b0,
					eng_event_i.err.command_aborted_flag, 1'b0,
					eng_event_i.err.general_error_flag};
				s_d.error_flag  = |eng_event_i.err;
				if (~|eng_event_i.err) begin
					s_d.remain = `TF_COUNT_RST;
				end
			end
		end

		// Interrupt pending: completion or new transfer request
		s_d.drq_seen = eng_level_i.transfer_request;
		// Clear first so a same-cycle set below wins
		if (status_rd) begin
			s_d.irq_pending = 1'b0;
		end
		if (((s_q.phase == ata_tf_pkg::ST_EXEC) && eng_event_i.done) ||
			(eng_level_i.transfer_request && !s_q.drq_seen)) begin
			s_d.irq_pending = 1'b1;
		end

		// Host reads
		if (taken && tf_req_i.rd) begin
			s_d.rvalid = 1'b1;
			case (tf_req_i.sel)
				`TF_SEL_DATA: begin
					s_d.rdata = s_q.rbuf[s_q.rhead];
				end
				`TF_SEL_ERR_FEAT: begin
					s_d.rdata = {8'h00, s_q.error_cause};
				end
				`TF_SEL_COUNT: begin
					s_d.rdata = {8'h00, shown_count};
				end
				`TF_SEL_ADDR0: begin
					s_d.rdata = {8'h00, shown_byte0};
				end
				`TF_SEL_ADDR1: begin
					s_d.rdata = {8'h00, shown_byte1};
				end
				`TF_SEL_ADDR2: begin
					s_d.rdata = {8'h00, shown_byte2};
				end
				`TF_SEL_DEVHEAD: begin
					s_d.rdata = {8'h00, shown_devhead};
				end
				`TF_SEL_STAT_CMD: begin
					s_d.rdata = {8'h00, status};
				end
				`TF_SEL_CTRL_AUX: begin
					s_d.rdata = {8'h00, status};
				end
				`TF_SEL_MIRROR: begin
					s_d.rdata = {8'h00, mirror};
				end
				default: begin
					s_d.rdata = `TF_WORD_RST;
				end
			endcase
		end

		// Host writes to the command block, ignored while busy
		if (cmd_block_wr) begin
			s_d.high_order_readback = 1'b0;
			case (tf_req_i.sel)
				`TF_SEL_ERR_FEAT: begin
					s_d.feature_select = tf_req_i.wdata[7:0];
				end
				`TF_SEL_COUNT: begin
					s_d.prev_count = count_now;
					s_d.remain = {tf_req_i.wdata[7:0] == 8'h00,
						tf_req_i.wdata[7:0]};
				end
				`TF_SEL_ADDR0: begin
					s_d.prev_byte0    = s_q.address_byte0;
					s_d.address_byte0 = tf_req_i.wdata[7:0];
				end
				`TF_SEL_ADDR1: begin
					s_d.prev_byte1    = s_q.address_byte1;
					s_d.address_byte1 = tf_req_i.wdata[7:0];
				end
				`TF_SEL_ADDR2: begin
					s_d.prev_byte2    = s_q.address_byte2;
					s_d.address_byte2 = tf_req_i.wdata[7:0];
				end
				`TF_SEL_DEVHEAD: begin
					// Stored as written; host keeps 7,5 set, drive 0
					s_d.prev_devhead = s_q.devhead;
					s_d.devhead      = tf_req_i.wdata[7:0];
				end
				`TF_SEL_STAT_CMD: begin
					s_d.corrected_data_flag = 1'b0;
					// Refused commands still end with an interrupt
					if (!eng_level_i.ready ||
						eng_level_i.write_fault) begin
						s_d.error_cause = 8'h04;
						s_d.error_flag  = 1'b1;
						s_d.irq_pending = 1'b1;
					end else begin
						s_d.phase       = ata_tf_pkg::ST_EXEC;
						s_d.error_cause = `TF_BYTE_RST;
						s_d.error_flag  = 1'b0;
						s_d.cmd_valid   = 1'b1;
						s_d.cmd_code    = tf_req_i.wdata[7:0];
					end
				end
				default: begin
					s_d.high_order_readback = 1'b0;
				end
			endcase
		end

		// Device control: bits 6-3 and 0 are not stored
		if (ctrl_wr) begin
			s_d.high_order_readback =
				tf_req_i.wdata[`CTRL_HOB_BIT];
			s_d.soft_reset_bit = tf_req_i.wdata[`CTRL_SRST_BIT];
			s_d.interrupt_disable_bit =
				tf_req_i.wdata[`CTRL_NIEN_BIT];
			if (tf_req_i.wdata[`CTRL_SRST_BIT]) begin
				s_d.phase = ata_tf_pkg::ST_SRST;
			end else if (s_q.phase == ata_tf_pkg::ST_SRST) begin
				s_d.phase = ata_tf_pkg::ST_IDLE;
			end
		end

		// Held in soft reset: error, status flags, interrupt state and buffers cleared
		// The control port stays open so the host can release it
		if (s_q.phase == ata_tf_pkg::ST_SRST) begin
			s_d.error_cause         = `TF_BYTE_RST;
			s_d.error_flag          = 1'b0;
			s_d.corrected_data_flag = 1'b0;
			s_d.irq_pending         = 1'b0;
			s_d.interrupt_disable_bit = 1'b0;
			s_d.wcnt                = 2'h0;
			s_d.rcnt                = 2'h0;
		end
	end

	// ======================================================================
	// State register
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// Phase named explicitly so its encoding may change
			s_q <= '0;
			s_q.phase <= ata_tf_pkg::ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ======================================================================
	// Outputs
	always_comb begin
		tf_rdata_o   = s_q.rdata;
		tf_rvalid_o  = s_q.rvalid;
		cmd_valid_o  = s_q.cmd_valid;
		cmd_code_o   = s_q.cmd_code;
		feature_o    = s_q.feature_select;
		busy_o       = busy;
		soft_reset_o = s_q.soft_reset_bit;
		intrq_o      = s_q.irq_pending && !s_q.interrupt_disable_bit;
		dev_wdata_o  = s_q.wbuf[s_q.whead];
		dev_wvalid_o = (s_q.wcnt != 2'h0);
		dev_rready_o = (s_q.rcnt != `TF_BUF_FULL);
	end

	// ======================================================================
	// Transfer parameters for the drive engine
	always_comb begin
		xfer_o.lba_mode = s_q.devhead[`DH_LBA_BIT];
		xfer_o.lba      = {s_q.devhead[3:0], s_q.address_byte2,
			s_q.address_byte1, s_q.address_byte0};
		xfer_o.cylinder = {s_q.address_byte2, s_q.address_byte1};
		xfer_o.head     = s_q.devhead[3:0];
		xfer_o.sector   = s_q.address_byte0;
		xfer_o.sectors  = s_q.remain;
	end

endmodule : ata_task_file_registers
`default_nettype wire

// *** test/ata_tf_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ata_tf_consts.svh"

module ata_tf_asserts (
	input wire logic                   ref_clk_i,
	input wire logic                   arst_n_i,
	input wire ata_tf_pkg::tf_req_t    tf_req_i,
	input wire logic                   tf_ready_o,
	input wire logic                   tf_rvalid_o,
	input wire ata_tf_pkg::eng_level_t eng_level_i,
	input wire ata_tf_pkg::eng_event_t eng_event_i,
	input wire logic                   cmd_valid_o,
	input wire logic [7:0]             cmd_code_o,
	input wire ata_tf_pkg::xfer_addr_t xfer_o,
	input wire logic                   busy_o,
	input wire logic                   soft_reset_o,
	input wire logic                   intrq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	// ======================================================================
	// Host accesses
	sequence rd_taken(logic [3:0] s);
		tf_req_i.rd && tf_ready_o && tf_req_i.sel == s;
	endsequence
	sequence wr_taken(logic [3:0] s);
		tf_req_i.wr && tf_ready_o && tf_req_i.sel == s;
	endsequence
	sequence cmd_go;
		wr_taken(`TF_SEL_STAT_CMD) ##0 !busy_o && eng_level_i.ready
			&& !eng_level_i.write_fault && !eng_level_i.transfer_request;
	endsequence

	// ======================================================================
	// Checks
	chk_read_answer: assert property (tf_req_i.rd && tf_ready_o |=> tf_rvalid_o)
		else $error("read not answered next cycle");
	chk_status_clears: assert property (rd_taken(`TF_SEL_STAT_CMD)
		##0 !eng_event_i.done && !$rose(eng_level_i.transfer_request)
		|=> !intrq_o)
		else $error("status read left interrupt up");
	chk_aux_keeps: assert property (rd_taken(`TF_SEL_CTRL_AUX) ##0 intrq_o
		|=> intrq_o) else $error("aux read dropped interrupt");
	chk_cmd_issue: assert property (cmd_go |=> cmd_valid_o
		&& cmd_code_o == $past(tf_req_i.wdata[7:0]))
		else $error("accepted command not issued");
	chk_refuse_cmd: assert property (wr_taken(`TF_SEL_STAT_CMD)
		##0 !eng_level_i.ready |=> !cmd_valid_o)
		else $error("command issued while not ready");
	chk_cmd_busy: assert property (cmd_valid_o
		&& !eng_level_i.transfer_request |-> busy_o)
		else $error("command running without busy");
	chk_done_frees: assert property (eng_event_i.done && !soft_reset_o
		&& !tf_req_i.wr |=> !busy_o) else $error("busy after done");
	chk_srst_busy: assert property (soft_reset_o |-> busy_o)
		else $error("soft reset without busy");
	chk_srst_hold: assert property (soft_reset_o && !(tf_req_i.wr
		&& tf_req_i.sel == `TF_SEL_CTRL_AUX) |=> soft_reset_o)
		else $error("soft reset released without write");
	chk_lba_map: assert property (xfer_o.lba
		== {xfer_o.head, xfer_o.cylinder, xfer_o.sector})
		else $error("address assembly wrong");
	chk_count_256: assert property (wr_taken(`TF_SEL_COUNT) ##0 !busy_o
		&& tf_req_i.wdata[7:0] == 8'h00 |=> xfer_o.sectors == 9'h100)
		else $error("zero count not 256");
endmodule : ata_tf_asserts

bind ata_task_file_registers ata_tf_asserts ata_tf_asserts_i (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tf_req_i(tf_req_i),
	.tf_ready_o(tf_ready_o), .tf_rvalid_o(tf_rvalid_o),
	.eng_level_i(eng_level_i), .eng_event_i(eng_event_i),
	.cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o), .xfer_o(xfer_o),
	.busy_o(busy_o), .soft_reset_o(soft_reset_o), .intrq_o(intrq_o));
`default_nettype wire

// *** test/ata_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module ata_host_model (
	input  wire logic          ref_clk_i,
	input  wire logic          tf_ready_i,
	input  wire logic          tf_rvalid_i,
	input  wire logic [15:0]   tf_rdata_i,
	output ata_tf_pkg::tf_req_t tf_req_o
);
	logic ok;

	initial tf_req_o = '0;

	// Holds the request until ready is seen at a falling edge, then through the next rising edge
	task automatic wait_taken();
		do begin
			@(negedge ref_clk_i);
			ok = tf_ready_i;
			@(posedge ref_clk_i);
		end while (!ok);
	endtask : wait_taken

	// One 16-bit word per access, bus scrambled once released
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		tf_req_o <= '{1'b1, 1'b0, s, d};
		wait_taken();
		tf_req_o <= '{1'b0, 1'b0, ~s, ~d};
		@(posedge ref_clk_i);
	endtask : wr

	task automatic rd(input logic [3:0] s, output logic [15:0] d);
		tf_req_o <= '{1'b0, 1'b1, s, 16'h0000};
		wait_taken();
		tf_req_o <= '{1'b0, 1'b0, ~s, 16'hFFFF};
		@(negedge ref_clk_i);
		d = tf_rvalid_i ? tf_rdata_i : 16'hXXXX;
		@(posedge ref_clk_i);
	endtask : rd
endmodule : ata_host_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                   clk, arst_n, dev_wready, dev_rvalid;
	logic [15:0]            dev_rdata, r, w, rdata, wdata;
	logic                   ready, rvalid, cmdv, busy, srst, irq, wvalid;
	logic [7:0]             code, feat, dh, b0, b1, b2;
	ata_tf_pkg::eng_level_t lvl;
	ata_tf_pkg::eng_event_t ev;
	ata_tf_pkg::tf_req_t    req;
	ata_tf_pkg::xfer_addr_t xfer;
	int                     error_cnt, samples_checked, cycles, seed, i;
	logic [15:0]            got[$], sent[$];
	logic [7:0]             ecode[5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};

	ata_task_file_registers ata_task_file_registers_i (
		.ref_clk_i(clk), .arst_n_i(arst_n), .tf_req_i(req),
		.tf_ready_o(ready), .tf_rdata_o(rdata), .tf_rvalid_o(rvalid),
		.eng_level_i(lvl), .eng_event_i(ev), .cmd_valid_o(cmdv),
		.cmd_code_o(code), .feature_o(feat), .xfer_o(xfer), .busy_o(busy),
		.soft_reset_o(srst), .intrq_o(irq), .dev_wdata_o(wdata),
		.dev_wvalid_o(wvalid), .dev_wready_i(dev_wready),
		.dev_rdata_i(dev_rdata), .dev_rvalid_i(dev_rvalid),
		.dev_rready_o());
	ata_host_model host_i (.ref_clk_i(clk), .tf_ready_i(ready),
		.tf_rvalid_i(rvalid), .tf_rdata_i(rdata), .tf_req_o(req));

	// ======================================================================
	// Helpers
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [27:0] s, e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic rdc(input logic [3:0] a, input logic [15:0] e,
			input string n);
		host_i.rd(a, r);
		chk(n, 28'(r), 28'(e));
	endtask : rdc

	task automatic wrb(input logic [3:0] a, input logic [7:0] d);
		host_i.wr(a, {8'h00, d});
	endtask : wrb

	task automatic pulse(input logic [7:0] e);
		ev <= ata_tf_pkg::eng_event_t'(e);
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask : pulse

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			wrap_up();
		end
	end

	always @(negedge clk)
		if (wvalid && dev_wready)
			got.push_back(wdata);

	// ======================================================================
	// Scenarios
	initial begin
		seed = 15;
		arst_n = 1'b0;
		dev_wready = 1'b0;
		dev_rvalid = 1'b0;
		dev_rdata = 16'h0000;
		lvl = '0;
		ev = '0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rdc(4'h7, 16'h0000, "status_rst");
		for (i = 0; i < 2; i++) begin
			b0 = 8'($random(seed));
			b1 = 8'($random(seed));
			b2 = 8'($random(seed));
			dh = {1'b1, i[0], 2'b10, 4'($random(seed))};
			lvl.writing <= i[0];
			wrb(4'h3, b0);
			wrb(4'h4, b1);
			wrb(4'h5, b2);
			wrb(4'h6, dh);
			chk("lba", xfer.lba, {dh[3:0], b2, b1, b0});
			chk("mode", 28'(xfer.lba_mode), 28'(i[0]));
			rdc(4'hF, {9'h000, ~i[0], ~dh[3:0], 2'b10}, "mirror");
		end
		lvl.writing <= 1'b0;
		wrb(4'h1, b0);
		chk("feature", 28'(feat), 28'(b0));
		wrb(4'h2, 8'h05);
		wrb(4'h2, 8'h09);
		wrb(4'hE, 8'h89);
		rdc(4'h2, 16'h0005, "count_prev");
		chk("srst_ign", 28'(srst), 28'h0);
		wrb(4'h3, b0);
		rdc(4'h2, 16'h0009, "count_new");
		wrb(4'h2, 8'h00);
		chk("sectors", 28'(xfer.sectors), 28'h100);
		wrb(4'h7, 8'h20);
		rdc(4'h1, 16'h0004, "err_abort");
		rdc(4'hE, 16'h0001, "aux");
		chk("irq_aux", 28'(irq), 28'h1);
		rdc(4'h7, 16'h0001, "status_err");
		chk("irq_clr", 28'(irq), 28'h0);
		lvl <= 4'hC;
		wrb(4'h7, 8'h30);
		rdc(4'h1, 16'h0004, "err_wf");
		rdc(4'h7, 16'h0071, "status_wf");
		lvl <= 4'h8;
		wrb(4'h2, 8'h02);
		wrb(4'h7, 8'h30);
		rdc(4'h7, 16'h0080, "busy");
		chk("cmd_code", 28'(code), 28'h30);
		lvl <= 4'hA;
		repeat (2) @(posedge clk);
		chk("irq_drq", 28'(irq), 28'h1);
		rdc(4'h7, 16'h0058, "status_drq");
		repeat (3) begin
			w = 16'($random(seed));
			sent.push_back(w);
		end
		fork
			for (int k = 0; k < 3; k++)
				host_i.wr(4'h0, sent[k]);
		join_none
		repeat (8) @(posedge clk);
		chk("stall", 28'(ready), 28'h0);
		dev_wready <= 1'b1;
		wait fork;
		repeat (4) @(posedge clk);
		for (i = 0; i < 3; i++)
			chk("wdata", 28'(got[i]), 28'(sent[i]));
		lvl <= 4'h8;
		pulse(8'h40);
		pulse(8'h80);
		chk("irq_done", 28'(irq), 28'h1);
		rdc(4'h2, 16'h0000, "count_ok");
		rdc(4'h7, 16'h0050, "status_ok");
		wrb(4'h2, 8'h01);
		wrb(4'h7, 8'h20);
		lvl <= 4'hA;
		for (i = 0; i < 2; i++) begin
			dev_rdata <= sent[i];
			dev_rvalid <= 1'b1;
			@(posedge clk);
		end
		dev_rvalid <= 1'b0;
		dev_rdata <= ~sent[1];
		pulse(8'h20);
		rdc(4'h7, 16'h005C, "status_corrected_data_flag");
		for (i = 0; i < 2; i++)
			rdc(4'h0, sent[i], "rdata");
		lvl <= 4'h8;
		pulse(8'h80);
		for (i = 0; i < 5; i++) begin
			wrb(4'h2, 8'h03);
			wrb(4'h7, 8'h20);
			pulse(8'h40);
			pulse({3'b100, 5'(5'h10 >> i)});
			rdc(4'h1, {8'h00, ecode[i]}, "err_bits");
			rdc(4'h2, 16'h0002, "count_left");
			rdc(4'h7, 16'h0051, "status_fail");
		end
		wrb(4'hE, 8'h02);
		wrb(4'h7, 8'h20);
		pulse(8'h80);
		chk("irq_mask", 28'(irq), 28'h0);
		wrb(4'hE, 8'h00);
		chk("irq_unmask", 28'(irq), 28'h1);
		wrb(4'hE, 8'h04);
		repeat (5) @(posedge clk);
		chk("srst", 28'({srst, busy}), 28'h3);
		rdc(4'h7, 16'h0080, "status_srst");
		wrb(4'hE, 8'h00);
		chk("srst_end", 28'({srst, busy, irq}), 28'h0);
		rdc(4'h1, 16'h0000, "err_after");
		rdc(4'h7, 16'h0050, "status_after");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
